// >>> rtl/cao_regs.vh
`ifndef CAO_REGS_VH
`define CAO_REGS_VH
// byte addresses of the registers on the AXI4-Lite bus
`define CAO_ADDR_CTRL     8'h00
`define CAO_ADDR_MODE     8'h04
`define CAO_ADDR_CNT_LO   8'h08
`define CAO_ADDR_CNT_HI   8'h0C
`define CAO_ADDR_CPM0     8'h10
`define CAO_ADDR_CPL0     8'h14
`define CAO_ADDR_CPH0     8'h18
`define CAO_ADDR_CPM1     8'h1C
`define CAO_ADDR_CPL1     8'h20
`define CAO_ADDR_CPH1     8'h24
`define CAO_ADDR_CPM2     8'h28
`define CAO_ADDR_CPL2     8'h2C
`define CAO_ADDR_CPH2     8'h30
`define CAO_ADDR_STAT     8'h34
// counter_control_reg fields
`define CAO_CTRL_OVF      7
`define CAO_CTRL_RUN      6
// counter_mode_reg fields
`define CAO_MODE_IDLE     7
`define CAO_MODE_WDT_ENABLE_BIT     6
`define CAO_MODE_WDT_LOCK_BIT    5
`define CAO_MODE_TB_HI    3
`define CAO_MODE_TB_LO    1
`define CAO_MODE_OVF_IE   0
`define CAO_MODE_RESET    8'h40
// capcomp_mode_reg fields
`define CAO_CPM_WIDE      7
`define CAO_CPM_ECOM      6
`define CAO_CPM_CAPP      5
`define CAO_CPM_CAPN      4
`define CAO_CPM_MAT       3
`define CAO_CPM_TOG       2
`define CAO_CPM_PWM       1
`define CAO_CPM_IE        0
// timebase selections and dividers
`define CAO_TB_DIV12      3'h0
`define CAO_TB_DIV4       3'h1
`define CAO_TB_T0         3'h2
`define CAO_TB_EXT        3'h3
`define CAO_TB_SYS        3'h4
`define CAO_TB_EXT8       3'h5
`define CAO_DIV12_LAST    4'hB
`define CAO_DIV4_LAST     4'h3
`define CAO_DIV8_LAST     3'h7
// bus responses
`define CAO_RESP_OKAY     2'h0
`define CAO_RESP_SLVERR   2'h2
`endif

// >>> rtl/cao_counter_array.v
`timescale 1ns/1ns
`include "cao_regs.vh"
module cao_counter_array (
  input  wire        clock,
  input  wire        reset,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        timer0_overflow,
  input  wire        ext_count_pin,
  input  wire        ext_osc_clock,
  input  wire        cpu_idle,
  output reg  [2:0]  compare_output_pin,
  output reg         wdt_reset_r
);
  // ==========================================================
  // state
  // ==========================================================
  reg  [7:0]  ctrl_r;
  reg  [7:0]  mode_r;
  reg  [15:0] cnt_r;
  reg  [7:0]  cpm_r [0:2];
  reg  [7:0]  cpl_r [0:2];
  reg  [7:0]  cph_r [0:2];
  reg  [2:0]  hs_prev_r;
  reg  [3:0]  div_r;
  reg  [2:0]  div8_r;
  reg  [1:0]  eci_sync_r;
  reg         eci_last_r;
  reg  [1:0]  t0_sync_r;
  reg  [1:0]  osc_sync_r;
  reg         osc_last_r;
  reg  [1:0]  idle_sync_r;
  reg         aw_hold_r;
  reg         w_hold_r;
  reg  [7:0]  aw_addr_r;
  reg  [7:0]  w_data_r;
  reg         w_strb_r;
  integer     i;
  integer     j;

  wire wdt_on   = mode_r[`CAO_MODE_WDT_ENABLE_BIT] | mode_r[`CAO_MODE_WDT_LOCK_BIT];
  wire cnt_run  = ctrl_r[`CAO_CTRL_RUN] | wdt_on;
  wire idle_hold = mode_r[`CAO_MODE_IDLE] & idle_sync_r[1];
  wire [2:0] tb = mode_r[`CAO_MODE_TB_HI:`CAO_MODE_TB_LO];
  reg  tb_src;

  // ==========================================================
  // timebase
  // ==========================================================
  always @* begin
    // reserved timebase codes leave the counter stopped
    case (tb)
      `CAO_TB_DIV12: tb_src = (div_r == `CAO_DIV12_LAST);
      `CAO_TB_DIV4:  tb_src = (div_r[1:0] == `CAO_DIV4_LAST);
      `CAO_TB_T0:    tb_src = t0_sync_r[1];
      `CAO_TB_EXT:   tb_src = eci_last_r & ~eci_sync_r[1];
      `CAO_TB_SYS:   tb_src = 1'b1;
      `CAO_TB_EXT8:  tb_src = (div8_r == `CAO_DIV8_LAST) & osc_sync_r[1] & ~osc_last_r;
      default:       tb_src = 1'b0;
    endcase
  end
  wire tick = tb_src & cnt_run & ~idle_hold;
  wire lo_wrap  = tick & (cnt_r[7:0] == 8'hFF);
  wire ovf_16   = tick & (cnt_r == 16'hFFFF);
  // the pins are registered, so PWM edges are decided from the value the
  // counter is about to take; the pin then changes together with the count
  wire [7:0]  cnt_lo_nxt = cnt_r[7:0] + 8'h01;
  wire [15:0] cnt_nxt    = cnt_r + 16'h0001;

  // ==========================================================
  // per-module compare results
  // ==========================================================
  wire [2:0] hit16;
  wire [2:0] hit16_nxt;
  wire [2:0] hit8_nxt;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : cmp
      wire [15:0] word = {cph_r[g], cpl_r[g]};
      assign hit16[g]     = (cnt_r == word);
      assign hit16_nxt[g] = (cnt_nxt == word);
      assign hit8_nxt[g]  = (cnt_lo_nxt == cpl_r[g]);
    end
  endgenerate

  // ==========================================================
  // bus write decode
  // ==========================================================
  // a write lands once both channels are held and no answer is pending
  wire wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire wr_en = wr_go & w_strb_r;
  wire [7:0] wa = aw_addr_r;
  wire [7:0] wd = w_data_r;
  wire wa_ok = (wa[1:0] == 2'b00) & (wa <= `CAO_ADDR_STAT);

  // watchdog expiry and forced reset
  wire [15:0] cmp2 = {cph_r[2], cpl_r[2]};
  wire wdt_hit = wdt_on & lo_wrap & (cph_r[2] == cnt_r[15:8]);
  // forcing needs the watchdog running; the flag bit itself is written anyway
  wire wdt_force = wdt_on & wr_en & (wa == `CAO_ADDR_CTRL) & wd[2];

  always @(posedge clock) begin
    if (reset) begin
      div_r       <= 4'h0;
      div8_r      <= 3'h0;
      eci_sync_r  <= 2'h0;
      eci_last_r  <= 1'b0;
      t0_sync_r   <= 2'h0;
      osc_sync_r  <= 2'h0;
      osc_last_r  <= 1'b0;
      idle_sync_r <= 2'h0;
    end else begin
      div_r       <= (div_r == `CAO_DIV12_LAST) ? 4'h0 : div_r + 4'h1;
      eci_sync_r  <= {eci_sync_r[0], ext_count_pin};
      eci_last_r  <= eci_sync_r[1];
      t0_sync_r   <= {t0_sync_r[0], timer0_overflow};
      osc_sync_r  <= {osc_sync_r[0], ext_osc_clock};
      osc_last_r  <= osc_sync_r[1];
      idle_sync_r <= {idle_sync_r[0], cpu_idle};
      // the oscillator prescaler advances on synchronised rising edges only
      if (osc_sync_r[1] & ~osc_last_r)
        div8_r <= div8_r + 3'h1;
    end
  end

  // ==========================================================
  // counter, control and mode registers
  // ==========================================================
  always @(posedge clock) begin
    if (reset) begin
      ctrl_r      <= 8'h00;
      mode_r      <= `CAO_MODE_RESET;
      cnt_r       <= 16'h0000;
      wdt_reset_r <= 1'b0;
    end else begin
      wdt_reset_r <= wdt_hit | wdt_force;
      if (tick)
        cnt_r <= cnt_nxt;
      if (wr_en & ~wdt_on & (wa == `CAO_ADDR_CNT_LO))
        cnt_r[7:0] <= wd;
      if (wr_en & ~wdt_on & (wa == `CAO_ADDR_CNT_HI))
        cnt_r[15:8] <= wd;
      if (wr_en & (wa == `CAO_ADDR_MODE)) begin
        if (~wdt_on) begin
          // bit 4 is unused and always reads zero
          mode_r <= wd & 8'hEF;
        end else if (~mode_r[`CAO_MODE_WDT_LOCK_BIT]) begin
          // only the enable and lock bits may be written while running
          mode_r[`CAO_MODE_WDT_ENABLE_BIT]  <= wd[`CAO_MODE_WDT_ENABLE_BIT];
          mode_r[`CAO_MODE_WDT_LOCK_BIT] <= wd[`CAO_MODE_WDT_LOCK_BIT];
        end
      end
      // flags: hardware set wins over software clear
      if (wr_en & (wa == `CAO_ADDR_CTRL))
        // reserved control bits read back as zero
        ctrl_r <= {wd[7:6], 3'b000, wd[2:0]};
      if (ovf_16)
        ctrl_r[`CAO_CTRL_OVF] <= 1'b1;
      for (j = 0; j < 3; j = j + 1)
        if (tick & cpm_r[j][`CAO_CPM_MAT] & cpm_r[j][`CAO_CPM_ECOM] & hit16[j])
          ctrl_r[j] <= 1'b1;
    end
  end

  // ==========================================================
  // compare modules
  // ==========================================================
  always @(posedge clock) begin
    if (reset) begin
      for (i = 0; i < 3; i = i + 1) begin
        cpm_r[i] <= 8'h00;
        cpl_r[i] <= 8'h00;
        cph_r[i] <= 8'h00;
      end
      compare_output_pin <= 3'b000;
      hs_prev_r          <= 3'b000;
    end else begin
      for (i = 0; i < 3; i = i + 1) begin : mod
        reg ecom;
        reg tog;
        reg pwm;
        reg mat;
        reg hs;
        ecom = cpm_r[i][`CAO_CPM_ECOM];
        tog  = cpm_r[i][`CAO_CPM_TOG];
        pwm  = cpm_r[i][`CAO_CPM_PWM];
        mat  = cpm_r[i][`CAO_CPM_MAT];
        if (i == 2 && wdt_on) begin
          // software-timer behaviour only; pin held
          pwm = 1'b0;
          tog = 1'b0;
        end
        hs = ecom & tog & mat & ~pwm;
        // any entry into high-speed mode, a re-entry too, restarts the pin at 1
        hs_prev_r[i] <= hs;
        if (hs & ~hs_prev_r[i]) begin
          compare_output_pin[i] <= 1'b1;
        end else if (hs) begin
          if (tick & hit16[i])
            compare_output_pin[i] <= ~compare_output_pin[i];
        end else if (ecom & tog & pwm) begin
          if (tick & (cnt_r[7:0] == cpl_r[i])) begin
            compare_output_pin[i] <= ~compare_output_pin[i];
            // a zero step wraps the low byte onto itself: 256 ticks
            cpl_r[i] <= cpl_r[i] + cph_r[i];
          end
        end else if (pwm & ~cpm_r[i][`CAO_CPM_WIDE]) begin
          if (lo_wrap) begin
            // the reload applies from count 0x00, so a zero high byte
            // keeps the pin high straight across the wrap
            compare_output_pin[i] <= (cph_r[i] == 8'h00);
            cpl_r[i] <= cph_r[i];
          end else if (ecom & tick & hit8_nxt[i]) begin
            compare_output_pin[i] <= 1'b1;
          end
        end else if (pwm) begin
          if (ovf_16) begin
            // same for a zero word: the pin never drops
            compare_output_pin[i] <= (cph_r[i] == 8'h00) & (cpl_r[i] == 8'h00);
          end else if (ecom & tick & hit16_nxt[i]) begin
            compare_output_pin[i] <= 1'b1;
          end
        end
        if (pwm & ~ecom)
          compare_output_pin[i] <= 1'b0;
        // byte writes; the side effects on compare_enable hold except for module 2 while the watchdog runs
        if (wr_en && wa == `CAO_ADDR_CPM0 + 8'h0C * i[7:0] &&
            !(i == 2 && wdt_on))
          cpm_r[i] <= wd;
        if (wr_en && wa == `CAO_ADDR_CPL0 + 8'h0C * i[7:0]) begin
          cpl_r[i] <= wd;
          if (!(i == 2 && wdt_on))
            cpm_r[i][`CAO_CPM_ECOM] <= 1'b0;
        end
        if (wr_en && wa == `CAO_ADDR_CPH0 + 8'h0C * i[7:0]) begin
          if (i == 2 && wdt_on) begin
            cph_r[i] <= cnt_r[15:8] + cpl_r[i];
          end else begin
            cph_r[i] <= wd;
            cpm_r[i][`CAO_CPM_ECOM] <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  // ==========================================================
  always @(posedge clock) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CAO_RESP_OKAY;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 8'h00;
      w_strb_r      <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_r     <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_r     <= 1'b1;
        w_data_r     <= s_axi_wdata[7:0];
        w_strb_r     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_ok ? `CAO_RESP_OKAY : `CAO_RESP_SLVERR;
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read data is taken from the address while arready is high
  reg [7:0] rd_byte;
  reg       rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `CAO_ADDR_CTRL:   rd_byte = ctrl_r;
      `CAO_ADDR_MODE:   rd_byte = mode_r;
      `CAO_ADDR_CNT_LO: rd_byte = cnt_r[7:0];
      `CAO_ADDR_CNT_HI: rd_byte = cnt_r[15:8];
      `CAO_ADDR_CPM0:   rd_byte = cpm_r[0];
      `CAO_ADDR_CPL0:   rd_byte = cpl_r[0];
      `CAO_ADDR_CPH0:   rd_byte = cph_r[0];
      `CAO_ADDR_CPM1:   rd_byte = cpm_r[1];
      `CAO_ADDR_CPL1:   rd_byte = cpl_r[1];
      `CAO_ADDR_CPH1:   rd_byte = cph_r[1];
      `CAO_ADDR_CPM2:   rd_byte = cpm_r[2];
      `CAO_ADDR_CPL2:   rd_byte = cpl_r[2];
      `CAO_ADDR_CPH2:   rd_byte = cph_r[2];
      `CAO_ADDR_STAT:   rd_byte = {4'h0, wdt_on, compare_output_pin};
      default: begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CAO_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_byte};
        s_axi_rresp   <= rd_ok ? `CAO_RESP_OKAY : `CAO_RESP_SLVERR;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  wire unused_ok = ^cmp2;
endmodule

// >>> tb/cao_counter_array_asserts.sv
`timescale 1ns/1ns
// ==========================================
// port checks for the counter array
module cao_counter_array_asserts (
  input wire        clock,
  input wire        reset,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [2:0]  compare_output_pin,
  input wire        wdt_reset_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // reset itself is the cause here, so this one must not be disabled by it
  AST_RST_OUT: assert property (disable iff (1'b0)
    reset |=> compare_output_pin == 3'h0 && !wdt_reset_r) else $error("outputs not cleared");
  AST_WDT_PULSE: assert property ($rose(wdt_reset_r) |=> !wdt_reset_r)
    else $error("reset request longer than one cycle");
  AST_B_ANSWER: assert property (s_wtake |-> ##2 s_axi_bvalid) else $error("no write answer");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_ANSWER: assert property (s_rtake |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("bad read answer");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_UNMAPPED: assert property (s_wtake ##0 s_axi_awaddr > 8'h34 |-> ##2 s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
endmodule
bind cao_counter_array cao_counter_array_asserts chk_i (.clock, .reset, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .compare_output_pin, .wdt_reset_r);

// >>> tb/cao_pin_model.sv
`timescale 1ns/1ns
// ==========================================
// load on the output pins: counts high samples and level changes of one pin
module cao_pin_model (
  input wire       clock,
  input wire [2:0] pins,
  input wire [1:0] sel,
  input wire       clr,
  input wire       meas,
  output int       highs,
  output int       edges
);
  logic prev_r = 1'b0;
  always @(posedge clock) begin
    prev_r <= pins[sel];
    if (clr) begin
      highs <= 0;
      edges <= 0;
    end else if (meas) begin
      highs <= highs + int'(pins[sel]);
      edges <= edges + int'(pins[sel] != prev_r);
    end
  end
endmodule

// >>> tb/tb_cao_counter_array.sv
`timescale 1ns/1ns
`include "cao_regs.vh"
// ==========================================
// bench: register traffic plus pin measurement
module tb_cao_counter_array;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, wdt_reset_r;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [2:0]  pins;
  logic [1:0]  sel = 2'h0;
  logic        clr = 1'b0, meas = 1'b0;
  int          highs, edges, checks = 0, mismatches = 0, cyc = 0, pulses = 0, pcyc = 0;
  logic [7:0]  d, lo;
  logic [1:0]  r;
  logic [15:0] w;
  int          t0;

  cao_counter_array uut (.clock, .reset, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer0_overflow(1'b0), .ext_count_pin(1'b0), .ext_osc_clock(1'b0), .cpu_idle(1'b0),
    .compare_output_pin(pins), .wdt_reset_r);
  cao_pin_model far (.clock, .pins, .sel, .clr, .meas, .highs, .edges);

  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cyc <= reset ? 0 : cyc + 1;
    if (wdt_reset_r === 1'b1) begin
      pulses <= pulses + 1;
      pcyc <= cyc;
    end
  end

  task conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
      end
    end while (!bvalid);
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata[7:0];
        rready <= 1'b0;
      end
    end while (!rvalid);
  endtask
  // 512 samples cover whole periods, so the phase of the window does not matter
  task measure(input logic [1:0] s);
    sel <= s;
    repeat (300) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    meas <= 1'b1;
    repeat (512) @(posedge clock);
    meas <= 1'b0;
    @(posedge clock);
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    rd(`CAO_ADDR_MODE); chk(d, 8'h40);
    rd(`CAO_ADDR_CPL2); chk(d, 8'h00);
    rd(`CAO_ADDR_CTRL); chk(d & 8'h40, 8'h00);
    for (int i = 0; i < 4000 && pulses < 1; i++) @(posedge clock);
    chk(pcyc >= 3064 && pcyc <= 3084, 1);
    wr(`CAO_ADDR_CTRL, 8'h04);
    repeat (8) @(posedge clock);
    chk(pulses, 2);
    wr(`CAO_ADDR_MODE, 8'h00); rd(`CAO_ADDR_MODE); chk(d, 8'h00);
    wr(8'h38, 8'h00); chk(r, `CAO_RESP_SLVERR);
    wr(`CAO_ADDR_MODE, 8'h08); rd(`CAO_ADDR_MODE); chk(d, 8'h08);
    wr(`CAO_ADDR_CTRL, 8'h40);
    wr(`CAO_ADDR_CPM0, 8'h42);
    wr(`CAO_ADDR_CPL0, 8'hC0); rd(`CAO_ADDR_CPM0); chk(d, 8'h02);
    wr(`CAO_ADDR_CPH0, 8'hC0); rd(`CAO_ADDR_CPM0); chk(d, 8'h42);
    measure(2'h0); chk(highs, 128);
    wr(`CAO_ADDR_CPL0, 8'h00); measure(2'h0); chk(highs, 0);
    wr(`CAO_ADDR_CPH0, 8'h00); measure(2'h0); chk(highs, 512);
    wr(`CAO_ADDR_CPM1, 8'h46);
    wr(`CAO_ADDR_CPL1, 8'h00);
    wr(`CAO_ADDR_CPH1, 8'h10); measure(2'h1); chk(edges, 32);
    wr(`CAO_ADDR_CPL1, 8'h00);
    wr(`CAO_ADDR_CPH1, 8'h00); measure(2'h1); chk(edges, 2);
    wr(`CAO_ADDR_CPM1, 8'h4C);
    repeat (3) @(posedge clock);
    chk(pins[1], 1'b1);
    rd(`CAO_ADDR_CNT_LO); lo = d;
    rd(`CAO_ADDR_CNT_HI); w = {d, lo} + 16'h0100;
    wr(`CAO_ADDR_CPL1, w[7:0]);
    wr(`CAO_ADDR_CPH1, w[15:8]);
    for (int i = 0; i < 800 && pins[1] !== 1'b0; i++) @(posedge clock);
    chk(pins[1], 1'b0);
    // counter stopped and set just below the top, so the high phase up to one 16-bit overflow is seen
    wr(`CAO_ADDR_CTRL, 8'h00);
    wr(`CAO_ADDR_CPM2, 8'hCB);
    wr(`CAO_ADDR_CPL2, 8'hF0);
    wr(`CAO_ADDR_CPH2, 8'hFF);
    wr(`CAO_ADDR_CNT_LO, 8'hE0);
    wr(`CAO_ADDR_CNT_HI, 8'hFF);
    sel <= 2'h2;
    clr <= 1'b1;
    wr(`CAO_ADDR_CTRL, 8'h40);
    clr <= 1'b0;
    meas <= 1'b1;
    repeat (100) @(posedge clock);
    meas <= 1'b0;
    @(posedge clock);
    chk(highs, 16);
    rd(`CAO_ADDR_CTRL); chk(d & 8'h84, 8'h84);
    wr(`CAO_ADDR_CPL2, 8'h01);
    wr(`CAO_ADDR_MODE, 8'h48);
    rd(`CAO_ADDR_CNT_LO); lo = d;
    t0 = pulses;
    wr(`CAO_ADDR_CPH2, 8'h00);
    w = 16'(cyc);
    for (int i = 0; i < 2000 && pulses == t0; i++) @(posedge clock);
    chk(pcyc - int'(w) + int'(lo) >= 498 && pcyc - int'(w) + int'(lo) <= 516, 1);
    wr(`CAO_ADDR_MODE, 8'h68);
    wr(`CAO_ADDR_MODE, 8'h08); rd(`CAO_ADDR_MODE); chk(d & 8'h60, 8'h60);
    wr(`CAO_ADDR_CNT_HI, 8'hA5); rd(`CAO_ADDR_CNT_HI); chk(d == 8'hA5, 0);
    conclude();
  end
endmodule
